// File: verilog/flash_burst_protect_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - pump stays on only if next burst queued before current byte completes
// - rows are 64 bytes on A5..A0; continuation needs same row
// - first burst byte and row start use standard time, others burst time
// - nothing queued at completion: pump off, high voltage removed
// - no command processed while access error set; write one to clear
// - array write before divider written sets access error
// - array write with buffer empty flag clear sets access error
// - second array or command write before launch sets access error
// - control write other than command after array write sets error
// - only the five legal command codes; others set access error
// - after command write, any control access but launch sets error
// - stop during program or erase aborts and sets access error
// - secured debug port may only blank check or mass erase
// - writing zero to buffer empty flag cancels and sets error
// - protected region from a 512-byte boundary to top is locked
// - boundary register loads from nonvolatile protect byte at reset exit
// - application writes to boundary ignored; debug port may write
// - last unprotected address is boundary bits followed by ones
// - protection only when protect disable bit is zero
// - redirection enabled when no redirect bit is zero
// - redirect only when some but not all of array is protected
// - interrupt vectors redirected, reset vector never
module flash_burst_protect_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int DIV_WIDTH = 7
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // cpu / debug bus
  input wire logic i_bus_wr,
  input wire logic i_bus_rd,
  input wire logic [15:0] i_bus_addr,
  input wire logic [7:0] i_bus_wdata,
  input wire logic i_bus_from_debug,
  output logic [7:0] o_bus_rdata,
  input wire logic i_secured,
  input wire logic i_stop_mode,
  // nonvolatile bytes sampled at reset exit
  input wire logic [7:0] i_nv_protect_byte,
  input wire logic [7:0] i_nv_option_byte,
  // vector fetch path
  input wire logic [15:0] i_fetch_addr,
  output logic [15:0] o_fetch_addr,
  // array side
  output logic o_pump_en,
  output logic o_prog_pulse,
  output logic o_erase_pulse,
  output logic o_mass,
  output logic [15:0] o_array_addr,
  output logic [7:0] o_array_data,
  input wire logic i_array_blank
);
  if (DIV_WIDTH != 7) begin : g_div_check
    $error("divider must be seven bits");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    seq_state_e state;
    logic loaded;
    logic [7:0] protect;
    logic no_redirect;
    logic div_set;
    logic [6:0] div;
    logic cbef;
    logic ccf;
    logic pviol;
    logic accerr;
    logic blank;
    logic got_addr;
    logic got_cmd;
    logic [15:0] addr;
    logic [7:0] data;
    logic [6:0] cmd;
    logic [6:0] run_cmd;
    logic [15:0] run_addr;
    logic [7:0] run_data;
    logic [14:0] ticks;
    logic pump;
    logic burst_prev;
    logic [15:0] last_burst_addr;
    logic [7:0] rdata;
  } ctrl_s;
  ctrl_s st_reg, st_next;

  logic tick;
  logic is_ctrl;
  logic is_array;
  logic ctrl_wr;
  logic ctrl_rd;
  logic arr_wr;
  logic launch_wr;
  logic cancel_wr;
  logic legal_cmd;
  logic debug_blocked;
  logic prot_on;
  logic [15:0] last_unprot;
  logic in_protect;
  logic busy;
  logic redirect_en;
  logic [14:0] std_ticks;
  logic burst_cont;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign is_ctrl = (i_bus_addr >= CTRL_REG_LO) && (i_bus_addr <= CTRL_REG_HI);
  assign is_array = (i_bus_addr >= ARRAY_BASE);
  assign ctrl_wr = i_bus_wr && is_ctrl;
  assign ctrl_rd = i_bus_rd && is_ctrl;
  assign arr_wr = i_bus_wr && is_array;
  assign launch_wr = ctrl_wr && (i_bus_addr == STATUS_REGISTER_ADDR) && i_bus_wdata[STAT_CBEF_BIT];
  assign cancel_wr = ctrl_wr && (i_bus_addr == STATUS_REGISTER_ADDR) && !i_bus_wdata[STAT_CBEF_BIT];
  assign legal_cmd = (i_bus_wdata[6:0] == CMD_BLANK_CHECK) || (i_bus_wdata[6:0] == CMD_BYTE_PROGRAM) ||
                     (i_bus_wdata[6:0] == CMD_BURST_PROGRAM) || (i_bus_wdata[6:0] == CMD_PAGE_ERASE) ||
                     (i_bus_wdata[6:0] == CMD_MASS_ERASE);
  // secured debug port limited to blank check and mass erase
  assign debug_blocked = i_secured && i_bus_from_debug &&
                         ((i_bus_wdata[6:0] == CMD_BYTE_PROGRAM) || (i_bus_wdata[6:0] == CMD_BURST_PROGRAM) ||
                          (i_bus_wdata[6:0] == CMD_PAGE_ERASE));
  assign busy = (st_reg.state != ST_IDLE);

  // ------------------------------------------------------------
  // protection and redirection
  // ------------------------------------------------------------
  // disable bit zero turns protection on
  assign prot_on = !st_reg.protect[PROTECT_DISABLE_POS];
  assign last_unprot = {st_reg.protect[7:1], 9'h1ff};
  // region above the last unprotected address is locked; mass erase would reach it
  assign in_protect = prot_on && ((st_reg.run_addr > last_unprot) ||
                                  (st_reg.run_cmd == CMD_MASS_ERASE && last_unprot != ARRAY_TOP));
  // partial protection only; whole array protected means no room below
  assign redirect_en = !st_reg.no_redirect && prot_on && (last_unprot >= ARRAY_BASE) && (last_unprot != ARRAY_TOP);
  // next byte sequential and not a new row
  assign burst_cont = (st_reg.run_addr[ROW_ADDR_BITS-1:0] != '0) &&
                      (st_reg.run_addr == st_reg.last_burst_addr + 16'h0001);
  // standard time unless continuing a burst in the same row with pump up
  assign std_ticks = (st_reg.run_cmd == CMD_BURST_PROGRAM && st_reg.pump && st_reg.burst_prev && burst_cont) ?
                     15'(BURST_PROG_TICKS) : 15'(BYTE_PROG_TICKS);

  flash_tick_div #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_div(st_reg.div),
    .i_run(busy),
    .o_tick(tick)
  );

  flash_vec_redirect u_vec (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_fetch_addr(i_fetch_addr),
    .i_redirect_en(redirect_en),
    .i_boundary_bits(st_reg.protect[7:1]),
    .o_fetch_addr(o_fetch_addr)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // take nonvolatile bytes on the first clock after reset release
    if (!st_reg.loaded) begin
      st_next.loaded = 1'b1;
      st_next.protect = i_nv_protect_byte;
      st_next.no_redirect = i_nv_option_byte[NO_REDIRECT_POS];
    end
    // register reads, answered one cycle later
    st_next.rdata = 8'h00;
    if (ctrl_rd) begin
      case (i_bus_addr)
        CLOCK_DIVIDER_ADDR: st_next.rdata = {st_reg.div_set, st_reg.div};
        PROTECT_BOUNDARY_ADDR: st_next.rdata = st_reg.protect;
        STATUS_REGISTER_ADDR: st_next.rdata = {st_reg.cbef, st_reg.ccf, st_reg.pviol, st_reg.accerr,
                                               1'b0, st_reg.blank, 2'b00};
        COMMAND_REGISTER_ADDR: st_next.rdata = {1'b0, st_reg.cmd};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // write one clears access error and violation flags
    if (ctrl_wr && i_bus_addr == STATUS_REGISTER_ADDR && i_bus_wdata[STAT_ACCERR_BIT]) begin
      st_next.accerr = 1'b0;
    end
    if (ctrl_wr && i_bus_addr == STATUS_REGISTER_ADDR && i_bus_wdata[STAT_PVIOL_BIT]) begin
      st_next.pviol = 1'b0;
    end
    // divider: write once, not while access error set
    if (ctrl_wr && i_bus_addr == CLOCK_DIVIDER_ADDR && !st_reg.div_set && !st_reg.accerr && !st_reg.got_addr) begin
      st_next.div_set = 1'b1;
      st_next.div = i_bus_wdata[6:0];
    end
    // only the debug port changes the boundary
    if (ctrl_wr && i_bus_addr == PROTECT_BOUNDARY_ADDR && i_bus_from_debug && !st_reg.got_addr) begin
      st_next.protect = i_bus_wdata;
    end
    // protocol accepted only with access error clear
    if (!st_reg.accerr) begin
      if (arr_wr) begin
        if (!st_reg.div_set || !st_reg.cbef || st_reg.got_addr) begin
          st_next.accerr = 1'b1;
        end else begin
          st_next.got_addr = 1'b1;
          st_next.addr = i_bus_addr;
          st_next.data = i_bus_wdata;
        end
      end else if (st_reg.got_cmd && (ctrl_rd || (ctrl_wr && !launch_wr))) begin
        // only the launch write is allowed after the code
        st_next.accerr = 1'b1;
      end else if (ctrl_wr && i_bus_addr == COMMAND_REGISTER_ADDR && st_reg.got_addr) begin
        if (st_reg.got_cmd || !legal_cmd || debug_blocked) begin
          st_next.accerr = 1'b1;
        end else begin
          st_next.got_cmd = 1'b1;
          st_next.cmd = i_bus_wdata[6:0];
        end
      end else if (st_reg.got_addr && cancel_wr) begin
        st_next.accerr = 1'b1;
      end else if (st_reg.got_addr && !st_reg.got_cmd && ctrl_wr && i_bus_addr != COMMAND_REGISTER_ADDR) begin
        // only the command register may follow the array write
        st_next.accerr = 1'b1;
      end else if (st_reg.got_cmd && launch_wr) begin
        // launch by writing one to the buffer empty flag
        st_next.cbef = 1'b0;
        st_next.ccf = 1'b0;
        st_next.got_addr = 1'b0;
        st_next.got_cmd = 1'b0;
        st_next.run_cmd = st_reg.cmd;
        st_next.run_addr = st_reg.addr;
        st_next.run_data = st_reg.data;
        st_next.state = ST_LOAD;
      end
    end
    // any error drops a partial command
    if (st_next.accerr && !st_reg.accerr) begin
      st_next.got_addr = 1'b0;
      st_next.got_cmd = 1'b0;
    end
    case (st_reg.state)
      ST_IDLE: begin
        st_next.state = st_next.state;
      end
      ST_LOAD: begin
        st_next.state = ST_RUN;
        st_next.blank = 1'b0;
        if (in_protect && st_reg.run_cmd != CMD_BLANK_CHECK) begin
          // locked region refuses program and erase
          st_next.pviol = 1'b1;
          st_next.pump = 1'b0;
          st_next.state = ST_IDLE;
          st_next.cbef = 1'b1;
          st_next.ccf = 1'b1;
        end else begin
          case (st_reg.run_cmd)
            CMD_PAGE_ERASE: st_next.ticks = 15'(PAGE_ERASE_TICKS);
            CMD_MASS_ERASE: st_next.ticks = 15'(MASS_ERASE_TICKS);
            CMD_BLANK_CHECK: st_next.ticks = 15'(BLANK_CHECK_TICKS);
            default: st_next.ticks = std_ticks;
          endcase
          st_next.pump = (st_reg.run_cmd != CMD_BLANK_CHECK);
          // buffer frees at start, so the next burst byte can queue
          st_next.cbef = 1'b1;
        end
      end
      ST_RUN: begin
        if (i_stop_mode) begin
          st_next.got_addr = 1'b0;
          st_next.got_cmd = 1'b0;
          st_next.accerr = 1'b1;
          st_next.pump = 1'b0;
          st_next.cbef = 1'b1;
          st_next.ccf = 1'b1;
          st_next.state = ST_IDLE;
        end else if (tick) begin
          if (st_reg.ticks > 15'h0001) begin
            st_next.ticks = st_reg.ticks - 15'h0001;
          end else begin
            st_next.ccf = st_reg.cbef ? 1'b1 : st_reg.ccf;
            if (st_reg.run_cmd == CMD_BLANK_CHECK) begin
              st_next.blank = i_array_blank;
            end
            st_next.burst_prev = (st_reg.run_cmd == CMD_BURST_PROGRAM);
            st_next.last_burst_addr = st_reg.run_addr;
            // a command launched while this one ran starts now
            if (!st_reg.cbef) begin
              st_next.run_cmd = st_reg.cmd;
              st_next.run_addr = st_reg.addr;
              st_next.run_data = st_reg.data;
              st_next.state = ST_LOAD;
            end
            // pump held only for a queued burst byte in the same row
            if (!(st_reg.run_cmd == CMD_BURST_PROGRAM && st_next.state == ST_LOAD &&
                  st_next.run_cmd == CMD_BURST_PROGRAM && st_next.run_addr == st_reg.run_addr + 16'h0001 &&
                  st_next.run_addr[ROW_ADDR_BITS-1:0] != '0)) begin
              st_next.pump = 1'b0;
            end
            if (st_next.state != ST_LOAD) begin
              st_next.state = ST_IDLE;
            end
          end
        end
        // a launch during run waits in the buffer
        if (st_next.state == ST_LOAD && st_reg.state == ST_RUN && !(tick && st_reg.ticks <= 15'h0001)) begin
          st_next.state = ST_RUN;
          st_next.run_cmd = st_reg.run_cmd;
          st_next.run_addr = st_reg.run_addr;
          st_next.run_data = st_reg.run_data;
          st_next.cbef = 1'b0;
          st_next.cmd = st_reg.cmd;
        end
      end
      default: st_next.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.protect <= PROTECT_RESET;
      st_reg.no_redirect <= 1'b1;
      st_reg.div <= DIVIDER_RESET;
      st_reg.cbef <= 1'b1;
      st_reg.ccf <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_bus_rdata = st_reg.rdata;
  assign o_pump_en = st_reg.pump;
  assign o_prog_pulse = (st_reg.state == ST_RUN) &&
                        (st_reg.run_cmd == CMD_BYTE_PROGRAM || st_reg.run_cmd == CMD_BURST_PROGRAM);
  assign o_erase_pulse = (st_reg.state == ST_RUN) &&
                         (st_reg.run_cmd == CMD_PAGE_ERASE || st_reg.run_cmd == CMD_MASS_ERASE);
  assign o_mass = (st_reg.run_cmd == CMD_MASS_ERASE);
  assign o_array_addr = st_reg.run_addr;
  assign o_array_data = st_reg.run_data;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_bad_code_errs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.accerr && st_reg.got_addr && !st_reg.got_cmd && ctrl_wr && i_bus_addr == COMMAND_REGISTER_ADDR
     && !legal_cmd) |=> st_reg.accerr)
    else $error("illegal code did not flag");
  a_nodiv_write_errs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.accerr && arr_wr && !st_reg.div_set) |=> (st_reg.accerr && !st_reg.got_addr))
    else $error("array write before divider not flagged");
  a_second_write_errs: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.accerr && arr_wr && st_reg.got_addr) |=> st_reg.accerr)
    else $error("second array write not flagged");
  a_cancel_sets_err: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.accerr && st_reg.got_addr && !st_reg.got_cmd && cancel_wr) |=> st_reg.accerr)
    else $error("cancel not flagged");
  a_stop_aborts_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_reg.state == ST_RUN && i_stop_mode) |=> (st_reg.accerr && !o_pump_en))
    else $error("stop did not abort");
  a_error_blocks_launch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_reg.accerr && st_reg.state == ST_IDLE) |=> (st_reg.state == ST_IDLE))
    else $error("command ran with access error set");
  a_app_protect_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_reg.loaded && ctrl_wr && i_bus_addr == PROTECT_BOUNDARY_ADDR && !i_bus_from_debug)
    |=> $stable(st_reg.protect))
    else $error("application changed boundary");
  a_protect_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_reg.state == ST_LOAD && in_protect && st_reg.run_cmd != CMD_BLANK_CHECK)
    |=> (st_reg.pviol && !o_pump_en && st_reg.state == ST_IDLE))
    else $error("protected region not refused");
  a_debug_code_block: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.accerr && st_reg.got_addr && !st_reg.got_cmd && ctrl_wr && i_bus_addr == COMMAND_REGISTER_ADDR
     && debug_blocked) |=> st_reg.accerr)
    else $error("secured debug code accepted");
endmodule : flash_burst_protect_ctrl
`default_nettype wire

// File: include/flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;
  // bus side register offsets (high page)
  localparam logic [15:0] CLOCK_DIVIDER_ADDR = 16'h1820;
  localparam logic [15:0] CTRL_REG_LO = 16'h1820;
  localparam logic [15:0] CTRL_REG_HI = 16'h1826;
  localparam logic [15:0] PROTECT_BOUNDARY_ADDR = 16'h1824;
  localparam logic [15:0] STATUS_REGISTER_ADDR = 16'h1825;
  localparam logic [15:0] COMMAND_REGISTER_ADDR = 16'h1826;
  // nonvolatile bytes
  localparam logic [15:0] NV_PROTECT_BYTE_ADDR = 16'hffbd;
  localparam logic [15:0] NV_OPTION_BYTE_ADDR = 16'hffbf;
  // array window
  localparam logic [15:0] ARRAY_BASE = 16'he000;
  localparam logic [15:0] ARRAY_TOP = 16'hffff;
  // vector range
  localparam logic [15:0] VECTOR_LO = 16'hffc0;
  localparam logic [15:0] VECTOR_HI = 16'hfffd;
  // status bit positions
  localparam int STAT_CBEF_BIT = 7;
  localparam int STAT_CCF_BIT = 6;
  localparam int STAT_PVIOL_BIT = 5;
  localparam int STAT_ACCERR_BIT = 4;
  localparam int STAT_BLANK_BIT = 2;
  // protection fields
  localparam int PROTECT_DISABLE_POS = 0;
  localparam int NO_REDIRECT_POS = 7;
  localparam int ROW_ADDR_BITS = 6;
  // command codes
  localparam logic [6:0] CMD_BLANK_CHECK = 7'h05;
  localparam logic [6:0] CMD_BYTE_PROGRAM = 7'h20;
  localparam logic [6:0] CMD_BURST_PROGRAM = 7'h25;
  localparam logic [6:0] CMD_PAGE_ERASE = 7'h40;
  localparam logic [6:0] CMD_MASS_ERASE = 7'h41;
  // reset values
  localparam logic [7:0] PROTECT_RESET = 8'hff;
  localparam logic [6:0] DIVIDER_RESET = 7'h00;
  // timing in flash timing clock periods
  localparam int unsigned BYTE_PROG_TICKS = 9;
  localparam int unsigned BURST_PROG_TICKS = 4;
  localparam int unsigned PAGE_ERASE_TICKS = 4000;
  localparam int unsigned MASS_ERASE_TICKS = 20000;
  localparam int unsigned BLANK_CHECK_TICKS = 1;
  typedef enum {ST_IDLE, ST_LOAD, ST_RUN} seq_state_e;
endpackage : flash_ctrl_pkg
`default_nettype wire

// File: verilog/flash_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
// divides the bus clock into a one-cycle timing tick
module flash_tick_div
  import flash_ctrl_pkg::*;
#(
  parameter int WIDTH = 7
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_div,
  input wire logic i_run,
  output logic o_tick
);
  typedef struct packed {
    logic [WIDTH+2:0] cnt;
    logic tick;
  } div_s;
  div_s st_reg, st_next;
  if (WIDTH < 1) begin : g_width_check
    $error("divider width too small");
  end
  // prescale by eight times (div + 1), restarted while idle
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!i_run) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= {i_div, 3'b111}) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_tick = st_reg.tick;
endmodule : flash_tick_div
`default_nettype wire

// File: verilog/flash_vec_redirect.sv
`timescale 1ns/10ps
`default_nettype none
// maps an instruction fetch address, vectors moved below the protected region
module flash_vec_redirect
  import flash_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_fetch_addr,
  input wire logic i_redirect_en,
  input wire logic [6:0] i_boundary_bits,
  output logic [15:0] o_fetch_addr
);
  typedef struct packed {
    logic [15:0] addr;
  } vec_s;
  vec_s st_reg, st_next;
  logic in_range;
  // interrupt vectors only, reset vector untouched
  assign in_range = (i_fetch_addr >= VECTOR_LO) && (i_fetch_addr <= VECTOR_HI);
  always_comb begin
    st_next = st_reg;
    st_next.addr = i_fetch_addr;
    // same low offsets, in the top of the unprotected space
    if (i_redirect_en && in_range) begin
      st_next.addr = {i_boundary_bits, 3'h7, i_fetch_addr[5:0]};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_fetch_addr = st_reg.addr;
  // reset vector passes through untouched
  a_vector_keeps_reset: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_fetch_addr >= 16'hfffe) |=> (o_fetch_addr == $past(i_fetch_addr)))
    else $error("reset vector fetch was moved");
endmodule : flash_vec_redirect
`default_nettype wire

// File: dv/flash_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// cpu bus master model
// ------
module flash_bus_model
  import flash_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata
);
  // strobes idle low; parked address is a pattern so stale values are never reused
  initial begin
    {o_wr, o_rd} = 2'b00;
    {o_addr, o_wdata} = {16'h5a5a, 8'ha5};
  end
  // one strobe cycle between falling edges; released lines show the inverse
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
    @(negedge i_mclk);
    {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
  endtask : wr
  // read data is registered at the strobe edge, settled by the next falling edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    {o_addr, o_rd} = {a, 1'b1};
    @(negedge i_mclk);
    {o_addr, o_rd} = {~a, 1'b0};
    d = i_rdata;
  endtask : rd
  task automatic issue(input logic [15:0] a, input logic [7:0] d, input logic [6:0] c);
    wr(a, d);
    wr(COMMAND_REGISTER_ADDR, {1'b0, c});
    wr(STATUS_REGISTER_ADDR, 8'h80);
  endtask : issue
endmodule : flash_bus_model
`default_nettype wire

// File: dv/flash_burst_protect_ctrl_bench.sv
`timescale 1ns/10ps
`default_nettype none
// ------
// flash controller bench
// ------
module flash_burst_protect_ctrl_bench
  import flash_ctrl_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic dbg = 1'b0;
  logic sec = 1'b0;
  logic stop = 1'b0;
  logic [15:0] fetch = 16'h0000;
  logic wr, rd, pump, prog, erase, mass;
  logic [7:0] wdata, rdata, s, adata;
  logic [15:0] addr, fetch_out, aaddr;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;
  // broken sequences: command, offending address, data, read instead of write
  logic [6:0] ec [6] = '{7'h00, 7'h00, 7'h00, 7'h00, 7'h20, 7'h20};
  logic [15:0] ea [6] = '{16'he001, 16'h1826, 16'h1825, 16'h1820, 16'h1824, 16'h1826};
  logic [7:0] ed [6] = '{8'h00, 8'h7f, 8'h00, 8'h05, 8'h00, 8'h20};
  logic er [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  // fetches and their targets with 0xfe00 and up protected
  logic [15:0] va [4] = '{16'hffe0, 16'hffc0, 16'hfffe, 16'hffbe};
  logic [15:0] vx [4] = '{16'hfde0, 16'hfdc0, 16'hfffe, 16'hffbe};
  flash_bus_model bus (.i_mclk(mclk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  // protect byte 0xfc guards 0xfe00 up; option byte clears the no-redirect bit
  flash_burst_protect_ctrl dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_bus_wr(wr), .i_bus_rd(rd), .i_bus_addr(addr),
    .i_bus_wdata(wdata), .i_bus_from_debug(dbg), .o_bus_rdata(rdata), .i_secured(sec), .i_stop_mode(stop),
    .i_nv_protect_byte(8'hfc), .i_nv_option_byte(8'h7f), .i_fetch_addr(fetch), .o_fetch_addr(fetch_out),
    .o_pump_en(pump), .o_prog_pulse(prog), .o_erase_pulse(erase), .o_mass(mass), .o_array_addr(aaddr),
    .o_array_data(adata),
    .i_array_blank(1'b1));
  // clock and hang guard, ceiling well above the longest run
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // register read under a mask, so unrelated sticky bits do not matter
  task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp, input logic [7:0] m);
    bus.rd(a, s);
    check(what, {8'h00, s & m}, {8'h00, exp});
  endtask : rchk
  // pump on-time from rise to fall; bounded in case it never rises
  task automatic pump_time();
    n = 0;
    for (int i = 0; i < 40000 && !(n > 0 && pump !== 1'b1); i++) begin
      @(negedge mclk);
      if (pump === 1'b1) n++;
    end
  endtask : pump_time
  task automatic err_case(input logic [6:0] c, input logic [15:0] a, input logic [7:0] d, input logic r);
    bus.wr(ARRAY_BASE, 8'h00);
    if (c != 7'h00) bus.wr(COMMAND_REGISTER_ADDR, {1'b0, c});
    if (r) bus.rd(a, s);
    else bus.wr(a, d);
    rchk("access error", STATUS_REGISTER_ADDR, 8'h10, 8'h10);
    bus.wr(STATUS_REGISTER_ADDR, 8'h30);
  endtask : err_case
  task automatic t_reset();
    rchk("status", STATUS_REGISTER_ADDR, 8'hc0, 8'hff);
    rchk("boundary", PROTECT_BOUNDARY_ADDR, 8'hfc, 8'hff);
    bus.wr(PROTECT_BOUNDARY_ADDR, 8'h00);
    rchk("boundary app write", PROTECT_BOUNDARY_ADDR, 8'hfc, 8'hff);
    $display("%m done");
  endtask : t_reset
  task automatic t_vectors();
    for (int i = 0; i < 4; i++) begin
      fetch = va[i];
      @(negedge mclk);
      check("fetch map", fetch_out, vx[i]);
    end
    $display("%m done");
  endtask : t_vectors
  // an array write before the divider raises the error flag, which is cleared before the divider is written
  task automatic t_errors();
    bus.issue(ARRAY_BASE, 8'h00, CMD_BYTE_PROGRAM);
    repeat (20) @(negedge mclk);
    check("pump no divider", {15'h0000, pump}, 16'h0000);
    rchk("no divider", STATUS_REGISTER_ADDR, 8'h10, 8'h10);
    bus.wr(STATUS_REGISTER_ADDR, 8'h10);
    rchk("cleared", STATUS_REGISTER_ADDR, 8'hc0, 8'hf0);
    bus.wr(CLOCK_DIVIDER_ADDR, 8'h00);
    rchk("divider", CLOCK_DIVIDER_ADDR, 8'h80, 8'hff);
    for (int i = 0; i < 6; i++) err_case(ec[i], ea[i], ed[i], er[i]);
    {dbg, sec} = 2'b11;
    err_case(7'h00, COMMAND_REGISTER_ADDR, {1'b0, CMD_BYTE_PROGRAM}, 1'b0);
    {dbg, sec} = 2'b00;
    $display("%m done");
  endtask : t_errors
  task automatic t_program();
    bus.issue(16'hfdff, 8'h5a, CMD_BYTE_PROGRAM);
    pump_time();
    check("byte time", 16'(n >= BYTE_PROG_TICKS * 8 && n <= BYTE_PROG_TICKS * 8 + 24), 16'h0001);
    check("array address", aaddr, 16'hfdff);
    check("array data", {8'h00, adata}, 16'h005a);
    bus.issue(16'hfe00, 8'h5a, CMD_BYTE_PROGRAM);
    rchk("protected", STATUS_REGISTER_ADDR, 8'he0, 8'hf0);
    bus.wr(STATUS_REGISTER_ADDR, 8'h20);
    $display("%m done");
  endtask : t_program
  // second byte queued once the buffer empties, pump must bridge both
  task automatic t_burst();
    bus.issue(16'he03e, 8'h11, CMD_BURST_PROGRAM);
    fork
      pump_time();
      begin
        s = 8'h00;
        for (int i = 0; i < 50 && s[7] !== 1'b1; i++) bus.rd(STATUS_REGISTER_ADDR, s);
        bus.issue(16'he03f, 8'h22, CMD_BURST_PROGRAM);
      end
    join
    check("burst time", 16'(n >= 104 && n <= 128), 16'h0001);
    $display("%m done");
  endtask : t_burst
  // blank check ends after one tick; page erase holds the pump for its whole time
  task automatic t_erase();
    bus.issue(ARRAY_BASE, 8'h00, CMD_BLANK_CHECK);
    repeat (12) @(negedge mclk);
    rchk("blank", STATUS_REGISTER_ADDR, 8'h44, 8'h44);
    bus.issue(ARRAY_BASE, 8'h00, CMD_PAGE_ERASE);
    @(negedge mclk);
    check("erase not mass", {14'h0000, erase, mass}, 16'h0002);
    pump_time();
    check("erase time", 16'(n >= PAGE_ERASE_TICKS * 8 - 1 && n <= PAGE_ERASE_TICKS * 8 + 24), 16'h0001);
    $display("%m done");
  endtask : t_erase
  task automatic t_stop();
    bus.issue(16'he001, 8'h33, CMD_BYTE_PROGRAM);
    repeat (10) @(negedge mclk);
    check("program pulse", {15'h0000, prog}, 16'h0001);
    stop = 1'b1;
    repeat (3) @(negedge mclk);
    check("pump after stop", {15'h0000, pump}, 16'h0000);
    stop = 1'b0;
    rchk("stop abort", STATUS_REGISTER_ADDR, 8'h10, 8'h10);
    $display("%m done");
  endtask : t_stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_vectors();
    t_errors();
    t_program();
    t_burst();
    t_erase();
    t_stop();
    final_report();
  end
endmodule : flash_burst_protect_ctrl_bench
`default_nettype wire
